//--- common/bdcfg_pkg.sv
/*
  Package for the boot/diagnostic configuration register: addresses,
  field positions and the carrier structs for the local bus and straps.
  Assumes a 32-bit physical address and 32-bit data local bus.
*/
package bdcfg_pkg;

  localparam logic [31:0] MAIN_ADDR   = 32'h1008_4004;
  localparam logic [31:0] DIAG_ADDR   = 32'h2008_4004;
  localparam int          HALT_BIT    = 7;
  localparam int          RATE_LSB    = 4;
  localparam int          RATE_W      = 3;
  localparam int          CPU_LSB     = 2;
  localparam int          CPU_W       = 2;
  localparam int          MODE_LSB    = 0;
  localparam int          MODE_W      = 2;
  localparam int          SYNC_STAGES = 2;
  localparam logic [7:0]  CFG_RST     = 8'h00;

  typedef enum logic [1:0] {
    BDCFG_SRC_MAIN,
    BDCFG_SRC_DIAG,
    BDCFG_SRC_EXT
  } bdcfg_src_e;

  typedef struct packed {
    logic        req;
    logic        wr;
    bdcfg_src_e  src;
    logic [31:0] addr;
  } bdcfg_req_s;

  typedef struct packed {
    logic                halt_permit_strap_n;
    logic [RATE_W-1:0]   rate_code;
    logic [CPU_W-1:0]    cpu_config_code;
    logic [MODE_W-1:0]   boot_mode_code;
  } bdcfg_strap_s;

endpackage : bdcfg_pkg

//--- core/bdcfg_reg.sv
/*
  Read-only boot/diagnostic configuration register with strap synchroniser
  and console-break halt gating.
  Assumes straps are static connector levels and one request per cycle.
*/
// Behaviour
// - Decode byte register at both processor addresses
// - Answer local processors, never expansion bus
// - Bit 7 shows halt strap, read-only
// - Halt strap gates break-triggered processor halt
// - Bits 6:4 give console rate code
// - Bits 3:2 give CPU configuration code
// - Bits 1:0 give boot mode code
`timescale 1ns/1ns
module bdcfg_reg #(
  parameter int SYNC_STAGES = bdcfg_pkg::SYNC_STAGES,
  parameter int CFG_W       = 8
) (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_srst,
  input  wire bdcfg_pkg::bdcfg_req_s   i_req,
  input  wire bdcfg_pkg::bdcfg_strap_s i_strap,
  input  wire logic                    i_console_break,
  output logic                         o_ack,
  output logic [31:0]                  o_rdata,
  output logic                         o_halt_req
);

  localparam int LAST = SYNC_STAGES - 1;

  // Fewer than two stages would let a metastable strap reach a read
  if (SYNC_STAGES < 2) begin : g_bad_depth
    $error("bdcfg_reg: SYNC_STAGES must be at least 2");
  end

  // The register is one byte wide, matching the strap carrier
  if (CFG_W != $bits(bdcfg_pkg::bdcfg_strap_s)) begin : g_bad_width
    $error("bdcfg_reg: CFG_W must equal the strap carrier width");
  end

  function automatic logic hit(input bdcfg_pkg::bdcfg_req_s r);
    hit = r.req && (r.src != bdcfg_pkg::BDCFG_SRC_EXT) &&
          ((r.addr == bdcfg_pkg::MAIN_ADDR) || (r.addr == bdcfg_pkg::DIAG_ADDR));
  endfunction : hit

  // Places each strap field at its register position
  function automatic logic [CFG_W-1:0] present(input bdcfg_pkg::bdcfg_strap_s s);
    logic [CFG_W-1:0] c;
    c = '0;
    c[bdcfg_pkg::HALT_BIT] = ~s.halt_permit_strap_n;
    c[bdcfg_pkg::RATE_LSB +: bdcfg_pkg::RATE_W] = s.rate_code;
    c[bdcfg_pkg::CPU_LSB +: bdcfg_pkg::CPU_W] = s.cpu_config_code;
    c[bdcfg_pkg::MODE_LSB +: bdcfg_pkg::MODE_W] = s.boot_mode_code;
    present = c;
  endfunction : present

  function automatic logic [31:0] read_word(input logic [CFG_W-1:0] c);
    read_word = {{(32-CFG_W){1'b0}}, c};
  endfunction : read_word

  logic [CFG_W-1:0]        sync_ff  [SYNC_STAGES];
  logic [CFG_W-1:0]        nxt_sync [SYNC_STAGES];
  bdcfg_pkg::bdcfg_strap_s strap_sync;
  logic [CFG_W-1:0]        cfg;
  logic                    ack_ff;
  logic                    nxt_ack;
  logic [31:0]             rdata_ff;
  logic [31:0]             nxt_rdata;
  logic                    halt_ff;
  logic                    nxt_halt;

  // multi-stage strap synchroniser
  // Cleared to zero, so bit 7 reads set until real straps arrive
  always_comb begin
    nxt_sync[0] = i_srst ? bdcfg_pkg::CFG_RST : i_strap;
    for (int s = 1; s < SYNC_STAGES; s++) begin
      nxt_sync[s] = i_srst ? bdcfg_pkg::CFG_RST : sync_ff[s-1];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    for (int s = 0; s < SYNC_STAGES; s++) begin
      sync_ff[s] <= nxt_sync[s];
    end
  end

  // Only the last stage is read; earlier stages may be metastable
  assign strap_sync = sync_ff[LAST];

  always_comb begin
    cfg = present(strap_sync);
  end

  always_comb begin
    nxt_ack = 1'b0;
    if (!i_srst && hit(i_req)) begin
      nxt_ack = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    ack_ff <= nxt_ack;
  end

  // Read data stands for one cycle only, zero otherwise
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (!i_srst && hit(i_req) && !i_req.wr) begin
      nxt_rdata = read_word(cfg);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    rdata_ff <= nxt_rdata;
  end

  // break halts only when permitted
  // Uses the synchronised strap, so a strap change acts two cycles late
  always_comb begin
    nxt_halt = 1'b0;
    if (!i_srst) begin
      nxt_halt = i_console_break && cfg[bdcfg_pkg::HALT_BIT];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    halt_ff <= nxt_halt;
  end

  assign o_ack      = ack_ff;
  assign o_rdata    = rdata_ff;
  assign o_halt_req = halt_ff;

endmodule : bdcfg_reg

//--- tb/bdcfg_reg_asserts.sv
/* Port checker for bdcfg_reg. Assumes straps are held steady around each read. */
`timescale 1ns/1ns
module bdcfg_reg_asserts (
  input wire logic                    i_ref_clk, i_srst, i_console_break, o_ack, o_halt_req,
  input wire bdcfg_pkg::bdcfg_req_s   i_req,
  input wire bdcfg_pkg::bdcfg_strap_s i_strap,
  input wire logic [31:0]             o_rdata);
  logic [1:0] rst_ff;
  wire hit = i_req.req && i_req.src != bdcfg_pkg::BDCFG_SRC_EXT &&
    (i_req.addr == bdcfg_pkg::MAIN_ADDR || i_req.addr == bdcfg_pkg::DIAG_ADDR);
  // Synchroniser holds reset zeros until two clean edges have passed
  wire rd = hit && !i_req.wr && rst_ff == 2'h0;
  always_ff @(posedge i_ref_clk) rst_ff <= {rst_ff[0], i_srst};
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  hit_ack_a: assert property (hit |=> o_ack) else $error("no ack");
  miss_ack_a: assert property (!hit |=> !o_ack) else $error("bad ack");
  miss_zero_a: assert property (!hit |=> o_rdata == 0) else $error("bad data");
  wr_zero_a: assert property (hit && i_req.wr |=> o_rdata == 0) else $error("wr");
  halt_bit_a: assert property (rd |=> o_rdata[7] != $past(i_strap[7], 3)) else $error("b7");
  rate_code_a: assert property (rd |=> o_rdata[6:4] == $past(i_strap[6:4], 3)) else $error("r");
  cpu_code_a: assert property (rd |=> o_rdata[3:2] == $past(i_strap[3:2], 3)) else $error("c");
  mode_code_a: assert property (rd |=> o_rdata[1:0] == $past(i_strap[1:0], 3)) else $error("m");
  halt_gate_a: assert property (rst_ff == 0 |=> o_halt_req ==
    ($past(i_console_break) && !$past(i_strap[7], 3))) else $error("halt");
  cover property (rd);
  cover property (hit && i_req.wr);
  cover property (o_halt_req);
endmodule : bdcfg_reg_asserts
bind bdcfg_reg bdcfg_reg_asserts chk (.i_ref_clk, .i_srst, .i_console_break, .o_ack,
  .o_halt_req, .i_req, .i_strap, .o_rdata);

//--- tb/bdcfg_cpu_model.sv
/* Processor side of the local bus. Assumes one access at a time. */
`timescale 1ns/1ns
module bdcfg_cpu_model (
  input  wire logic            i_ref_clk,
  output bdcfg_pkg::bdcfg_req_s o_req);
  initial o_req = '0;
  task automatic access(input logic w, input logic [1:0] s, input logic [31:0] a);
    @(posedge i_ref_clk) #1 o_req = {1'b1, w, s, a};
    // Scrambled address once released, so a stale hold shows up
    @(posedge i_ref_clk) #1 o_req = {1'b0, w, s, ~a};
  endtask : access
endmodule : bdcfg_cpu_model

//--- tb/boot_diag_config_register_tb_top.sv
/* Bench for bdcfg_reg: table of accesses, strap change, halt gate. Assumes the model above. */
`timescale 1ns/1ns
module boot_diag_config_register_tb_top;
  logic clk = 0, srst = 1, brk = 0, ack, halt;
  logic [31:0] rd;
  bdcfg_pkg::bdcfg_req_s req;
  bdcfg_pkg::bdcfg_strap_s strap = 8'h5a;
  int errors = 0, comparisons = 0;
  logic [51:0] rows [5] = '{52'h0010084004_1da, 52'h0120084004_1da, 52'h0210084004_000,
                            52'h1010084004_100, 52'h0010084008_000};
  bdcfg_reg dut (.i_ref_clk(clk), .i_srst(srst), .i_req(req), .i_strap(strap),
    .i_console_break(brk), .o_ack(ack), .o_rdata(rd), .o_halt_req(halt));
  bdcfg_cpu_model cpu (.i_ref_clk(clk), .o_req(req));
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task summarize;
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge clk);
    #1 chk({ack, rd}, 0);
    srst = 0;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      cpu.access(rows[i][48], rows[i][45:44], rows[i][43:12]);
      chk({ack, rd}, {rows[i][8], 24'h0, rows[i][7:0]});
    end
    brk = 1;
    @(posedge clk) #1 chk(halt, 1);
    strap = 8'hf7;
    repeat (4) @(posedge clk);
    #1 chk(halt, 0);
    brk = 0;
    cpu.access(0, 0, 32'h10084004);
    chk({ack, rd}, 33'h1_00000077);
    summarize();
  end
  initial begin
    #20000 errors++;
    summarize();
  end
endmodule : boot_diag_config_register_tb_top
